// ==== logic/led_ind_pkg.sv ====
// Purpose: shared constants and types for the latched indicator block
// Assumes: 125 MHz mclk, 32-bit Avalon-MM register port
// Notes: register field layouts and reset values live here; the status word is packed in the indicator
// Function
// - condition is OR of five invertible inputs
// - latch option holds indication once condition rises
// - acknowledge clears latch only when causes gone
// - acknowledge source ignored while latching disabled
// - true condition shows configured active appearance
// - false condition with no held latch shows configured inactive appearance
package led_ind_pkg;

	// signal and selector widths
	localparam int SIG_W = 32;
	localparam int SEL_W = 5;
	localparam int SLOTS = 5;
	localparam int ACK_W = 8;
	localparam int ACK_SEL_W = 3;
	localparam int FLASH_W = 27;
	localparam int ADDR_W = 4;

	// register byte addresses
	localparam logic [3:0] CFG_ADDR = 4'h0;
	localparam logic [3:0] ASSIGN_ADDR = 4'h4;
	localparam logic [3:0] FLASH_ADDR = 4'h8;
	localparam logic [3:0] STATUS_ADDR = 4'hC;

	// flash half period: time and derived cycle count
	localparam longint CLK_HZ = 125000000;
	localparam longint FLASH_HALF_MS = 500;
	localparam logic [26:0] FLASH_HALF_CYC =
		27'(CLK_HZ / 1000 * FLASH_HALF_MS);

	// appearance codes; unused codes show as off
	localparam logic [2:0] COL_OFF = 3'h0;
	localparam logic [2:0] COL_GREEN = 3'h1;
	localparam logic [2:0] COL_RED = 3'h2;
	localparam logic [2:0] COL_RED_FLASH = 3'h3;
	localparam logic [2:0] COL_GREEN_FLASH = 3'h4;

	// configuration word, bits [14:0] of the config register
	typedef struct packed {
		logic [2:0] ack_sel;
		logic [2:0] inactive;
		logic [2:0] active;
		logic latch_en;
		logic [4:0] invert;
	} cfg_s;

	// assignment word, bits [29:0] of the assignment register
	typedef struct packed {
		logic [4:0] en;
		logic [4:0][4:0] idx;
	} assign_s;

	// reset values: no inversion, no latch, red when true, off when false
	localparam cfg_s CFG_RESET = '{ack_sel: 3'h0, inactive: COL_OFF,
		active: COL_RED, latch_en: 1'b0, invert: 5'h00};
	localparam assign_s ASSIGN_RESET = '0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage

// ==== logic/flash_timer.sv ====
// Purpose: free running flash phase generator
// Assumes: half_count is stable between changes, same clock as user
// Notes: a count of zero is treated as one
`timescale 1ns/10ps
module flash_timer (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [26:0] half_count,
	output logic phase
);

	logic [26:0] count_reg; // cycles left in this half period
	logic [26:0] count_next;
	logic phase_reg; // current flash phase, 1 means lit
	logic phase_next;

	assign phase = phase_reg;

	// next count and phase
	always_comb begin
		count_next = count_reg - 27'h1;
		phase_next = phase_reg;
		if (count_reg <= 27'h1) begin
			count_next = half_count;
			phase_next = ~phase_reg;
		end
	end

	// registers only
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			count_reg <= 27'h1;
			phase_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			phase_reg <= phase_next;
		end
	end

endmodule

// ==== logic/latched_led_indicator.sv ====
// Purpose: one front panel indicator with OR, inversion, latch, colours
// Assumes: sig_in and ack_in come from logic on mclk, no sync needed
// Notes: registers reached over Avalon-MM; one wait state per access
`timescale 1ns/10ps
module latched_led_indicator #(
	parameter logic [26:0] FLASH_HALF_CYC = led_ind_pkg::FLASH_HALF_CYC
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [31:0] sig_in,
	input wire logic [7:0] ack_in,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic led_red,
	output logic led_green
);

	// merge write data into a register word under byte enables
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_word,
		input logic [31:0] wdata,
		input logic [3:0] be
	);
		logic [31:0] res;
		res = old_word;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = wdata[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// configuration registers
	led_ind_pkg::cfg_s cfg_reg; // inversion, latch, colours, ack source
	led_ind_pkg::cfg_s cfg_next;
	led_ind_pkg::assign_s asg_reg; // five input selections
	led_ind_pkg::assign_s asg_next;
	logic [26:0] half_reg; // flash half period in cycles
	logic [26:0] half_next;

	// bus slave state
	logic wait_reg; // waitrequest, high unless answering
	logic wait_next;
	logic [31:0] rdata_reg; // read data held for the master
	logic [31:0] rdata_next;
	logic [31:0] wmerged; // write word after byte lanes, cut to field

	// indicator state
	logic latched_reg; // held indication
	logic latched_next;
	logic red_reg; // red lamp drive
	logic red_next;
	logic green_reg; // green lamp drive
	logic green_next;

	// combinational helpers
	logic [4:0] hits; // per slot contribution after inversion
	logic cond; // OR of the slots
	logic ack_now; // selected acknowledge level
	logic shown; // state shown on the lamp
	logic [2:0] colour; // appearance now in force
	logic flash_phase; // common flash phase

	assign readdata = rdata_reg;
	assign waitrequest = wait_reg;
	assign led_red = red_reg;
	assign led_green = green_reg;

	// flash divider, shared phase for both flashing appearances
	flash_timer u_flash (
		.mclk(mclk),
		.reset_n(reset_n),
		.half_count(half_reg),
		.phase(flash_phase)
	);

	// bus: one wait cycle, then answer for exactly one cycle
	always_comb begin
		wait_next = 1'b1;
		rdata_next = rdata_reg;
		cfg_next = cfg_reg;
		asg_next = asg_reg;
		half_next = half_reg;
		wmerged = 32'h0000_0000;
		// first cycle of a request: prepare the answer
		if ((read || write) && wait_reg) begin
			wait_next = 1'b0;
			if (read) begin
				unique case (address)
					led_ind_pkg::CFG_ADDR:
						rdata_next = {17'h00000, cfg_reg};
					led_ind_pkg::ASSIGN_ADDR:
						rdata_next = {2'h0, asg_reg};
					led_ind_pkg::FLASH_ADDR:
						rdata_next = {5'h00, half_reg};
					led_ind_pkg::STATUS_ADDR:
						rdata_next = {21'h000000, red_reg, green_reg,
							flash_phase, shown, latched_reg, hits, cond};
					default:
						rdata_next = led_ind_pkg::RDATA_RESET;
				endcase
			end
		end
		// write takes effect on the edge that sees waitrequest low
		if (write && !wait_reg) begin
			unique case (address)
				// bits above each field are dropped on purpose
				led_ind_pkg::CFG_ADDR: begin
					wmerged = merge_bytes({17'h00000, cfg_reg},
						writedata, byteenable);
					cfg_next = led_ind_pkg::cfg_s'(wmerged[14:0]);
				end
				led_ind_pkg::ASSIGN_ADDR: begin
					wmerged = merge_bytes({2'h0, asg_reg},
						writedata, byteenable);
					asg_next = led_ind_pkg::assign_s'(wmerged[29:0]);
				end
				led_ind_pkg::FLASH_ADDR: begin
					wmerged = merge_bytes({5'h00, half_reg},
						writedata, byteenable);
					half_next = wmerged[26:0];
				end
				// status and unmapped: writes ignored
				default: begin
					half_next = half_reg;
				end
			endcase
		end
	end

	// bus and configuration registers
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			wait_reg <= 1'b1;
			rdata_reg <= led_ind_pkg::RDATA_RESET;
			cfg_reg <= led_ind_pkg::CFG_RESET;
			asg_reg <= led_ind_pkg::ASSIGN_RESET;
			half_reg <= FLASH_HALF_CYC;
		end else begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
			cfg_reg <= cfg_next;
			asg_reg <= asg_next;
			half_reg <= half_next;
		end
	end

	// condition: a slot counts only when enabled
	always_comb begin
		hits = 5'h00;
		for (int i = 0; i < led_ind_pkg::SLOTS; i++) begin
			hits[i] = asg_reg.en[i] &
				(sig_in[asg_reg.idx[i]] ^ cfg_reg.invert[i]);
		end
		cond = |hits;
	end

	// latch and acknowledge; a live cause always beats the acknowledge
	always_comb begin
		ack_now = ack_in[cfg_reg.ack_sel];
		latched_next = latched_reg;
		if (!cfg_reg.latch_en) begin
			latched_next = 1'b0;
		end else if (cond) begin
			latched_next = 1'b1;
		end else if (ack_now) begin
			latched_next = 1'b0;
		end
		// shown immediately, latch only extends it
		shown = cond | (cfg_reg.latch_en & latched_reg);
	end

	// appearance decode; illegal codes fall back to off
	always_comb begin
		colour = cfg_reg.active;
		if (!shown) begin
			colour = cfg_reg.inactive;
		end
		red_next = 1'b0;
		green_next = 1'b0;
		unique case (colour)
			led_ind_pkg::COL_OFF: begin
				red_next = 1'b0;
			end
			led_ind_pkg::COL_GREEN: begin
				green_next = 1'b1;
			end
			led_ind_pkg::COL_RED: begin
				red_next = 1'b1;
			end
			led_ind_pkg::COL_RED_FLASH: begin
				red_next = flash_phase;
			end
			led_ind_pkg::COL_GREEN_FLASH: begin
				green_next = flash_phase;
			end
			default: begin
				red_next = 1'b0;
			end
		endcase
	end

	// indicator registers
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			latched_reg <= 1'b0;
			red_reg <= 1'b0;
			green_reg <= 1'b0;
		end else begin
			latched_reg <= latched_next;
			red_reg <= red_next;
			green_reg <= green_next;
		end
	end

endmodule

// ==== verif/latched_led_indicator_monitor.sv ====
// Purpose: port checker for the latched indicator
// Assumes: config written as whole words
// Notes: keeps a shadow of the config word
`timescale 1ns/10ps
module latched_led_indicator_monitor #(
	parameter logic [26:0] FLASH_HALF_CYC = 27'h4
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [31:0] sig_in,
	input wire logic [7:0] ack_in,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic led_red,
	input wire logic led_green
);
	led_ind_pkg::cfg_s cfg_reg; // shadow config
	logic red_d; // lamp one cycle back
	logic [26:0] run; // cycles since red changed
	logic flash; // red flash in both states
	assign flash = cfg_reg.active == 3'h3 && cfg_reg.inactive == 3'h3;
	// shadow and run length; partial writes would be taken as whole words
	always_ff @(posedge mclk) begin
		red_d <= led_red;
		run <= (led_red != red_d || !flash) ? '0 : run + 27'h1;
		if (!reset_n)
			cfg_reg <= led_ind_pkg::CFG_RESET;
		else if (write && !waitrequest && address == 4'h0)
			cfg_reg <= writedata[14:0];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_wait_answer: assert property ((read || write) && waitrequest
		|=> !waitrequest) else $error("no answer after request");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("answer held too long");
	a_reset_dark: assert property (disable iff (1'b0) !reset_n
		|=> waitrequest && !led_red && !led_green) else $error("reset");
	a_one_colour: assert property (!(led_red && led_green))
		else $error("both colours lit");
	a_no_red: assert property (!(cfg_reg.active inside {3'h2, 3'h3}) &&
		!(cfg_reg.inactive inside {3'h2, 3'h3}) |=> !led_red)
		else $error("red lit without red colour");
	a_no_green: assert property (!(cfg_reg.active inside {3'h1, 3'h4}) &&
		!(cfg_reg.inactive inside {3'h1, 3'h4}) |=> !led_green)
		else $error("green lit without green colour");
	// config and ack steady one cycle back, so the lit lamp is held state
	a_latch_holds: assert property (cfg_reg.latch_en && led_red &&
		$stable(cfg_reg) && $past(ack_in) == 8'h00 &&
		cfg_reg.active == 3'h2 && cfg_reg.inactive == 3'h0 &&
		ack_in == 8'h00 |=> led_red) else $error("latch lost");
	a_flash_bound: assert property (flash |-> run <= FLASH_HALF_CYC)
		else $error("flash stopped toggling");
	cover property (flash && $changed(led_red));
	cover property (cfg_reg.latch_en && led_red);
	cover property (write && !waitrequest);
endmodule

bind latched_led_indicator latched_led_indicator_monitor #(
	.FLASH_HALF_CYC(FLASH_HALF_CYC)) mon (.mclk, .reset_n, .sig_in,
	.ack_in, .address, .read, .write, .writedata, .byteenable,
	.readdata, .waitrequest, .led_red, .led_green);

// ==== verif/latched_led_indicator_bench.sv ====
// Purpose: self-checking bench for the latched indicator
// Assumes: short flash half period of four cycles
// Notes: bus tasks wait on waitrequest
`timescale 1ns/10ps
module latched_led_indicator_bench;
	localparam logic [26:0] HALF = 27'h4; // short flash for speed
	logic mclk = 0, reset_n = 0, read = 0, write = 0;
	logic [31:0] sig_in = '0, writedata = '0, readdata;
	logic [7:0] ack_in = '0;
	logic [3:0] address = '0, byteenable = 4'hF;
	logic waitrequest, led_red, led_green;
	int errors = 0, num_checks = 0;
	always #4 mclk = ~mclk;
	latched_led_indicator #(.FLASH_HALF_CYC(HALF)) DUT (.mclk, .reset_n,
		.sig_in, .ack_in, .address, .read, .write, .writedata,
		.byteenable, .readdata, .waitrequest, .led_red, .led_green);
	task automatic check(input string n, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	// one access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check("readdata", q, e);
	endtask
	// status read; flash phase bit runs free, so it is masked
	task automatic rd_status(input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, led_ind_pkg::STATUS_ADDR, 32'h0, q);
		check("status", q & 32'hFFFF_FEFF, e);
	endtask
	// lamp settles one edge after the inputs
	task automatic drive(input logic [31:0] v);
		@(posedge mclk);
		sig_in <= v;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic lamp(input logic [1:0] e);
		check("lamp", {led_red, led_green}, e);
	endtask
	// ten cycles cover a whole flash period
	task automatic tally(input logic [2:0] k);
		int nr, ng;
		nr = 0;
		ng = 0;
		repeat (10) begin
			@(posedge mclk);
			#1;
			nr += (led_red === 1'b1);
			ng += (led_green === 1'b1);
		end
		check("red", {nr > 0, nr == 10}, {k == 2 || k == 3, k == 2});
		check("green", {ng > 0, ng == 10}, {k == 1 || k == 4, k == 1});
	endtask
	task automatic defaults();
		rd(led_ind_pkg::CFG_ADDR, 32'h80);
		rd(led_ind_pkg::ASSIGN_ADDR, 32'h0);
		rd(led_ind_pkg::FLASH_ADDR, 32'(HALF));
		rd(4'h2, 32'h0);
		drive('1);
		lamp(2'b00);
	endtask
	// each slot alone, then inverted; other bits must not count
	task automatic or_slots();
		logic [31:0] b;
		for (int i = 0; i < 5; i++) begin
			b = 32'h1 << (i + 7);
			wr(led_ind_pkg::ASSIGN_ADDR,
				32'(i + 7) << (5 * i) | 32'h1 << (25 + i));
			wr(led_ind_pkg::CFG_ADDR, 32'h80);
			drive(b);
			lamp(2'b10);
			drive(~b);
			lamp(2'b00);
			wr(led_ind_pkg::CFG_ADDR, 32'h80 | 32'h1 << i);
			drive(~b);
			lamp(2'b10);
			drive(b);
			lamp(2'b00);
		end
	endtask
	task automatic colours();
		wr(led_ind_pkg::ASSIGN_ADDR, 32'h0200_0003);
		for (int c = 0; c < 5; c++) begin
			wr(led_ind_pkg::CFG_ADDR, 32'(c << 6 | (4 - c) << 9));
			drive(32'h8);
			tally(3'(c));
			drive(32'h0);
			tally(3'(4 - c));
		end
		wr(led_ind_pkg::CFG_ADDR, 32'h6C0);
		drive(32'h8);
		tally(3'h3);
	endtask
	// ack while the cause stands, from the wrong source, then good
	task automatic latch();
		wr(led_ind_pkg::CFG_ADDR, 32'h50A0);
		drive(32'h8);
		drive(32'h0);
		lamp(2'b10);
		rd_status(32'h0000_04C0);
		drive(32'h8);
		@(posedge mclk);
		ack_in <= 8'h20;
		drive(32'h8);
		lamp(2'b10);
		@(posedge mclk);
		ack_in <= 8'h10;
		drive(32'h0);
		lamp(2'b10);
		@(posedge mclk);
		ack_in <= 8'h20;
		drive(32'h0);
		lamp(2'b00);
		wr(led_ind_pkg::CFG_ADDR, 32'h5080);
		drive(32'h8);
		drive(32'h0);
		lamp(2'b00);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge mclk);
		errors++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		defaults();
		or_slots();
		colours();
		latch();
		summarize();
	end
endmodule
